// *** hw/stp_prescaler.v ***
/*
 * Shared timer prescaler: divider taps, per-timer source select, external pin
 * edge counting, synchronisation hold, and an AHB-Lite register slave.
 * The slave answers with zero wait states and an OKAY response, and its read
 * data stand for the one data-phase cycle after the address phase.
 * Assumes two timers that advance by one on each timer_tick pulse.
 * Assumes count pins that are asynchronous to clk_sys and hold each level for
 * more than one system clock cycle.
 * Assumes a bus master that issues single word transfers only; hsize is not
 * decoded.
 */
// Implementation choices: the register offsets and register access over AHB-Lite.
`default_nettype none

module stp_prescaler
(
   input wire clk_sys,
   input wire rst_b,
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire external_count_pin_0,
   input wire external_count_pin_1,
   output reg timer_tick_0,
   output reg timer_tick_1,
   output reg second_prescaler_reset
);

`include "stp_regs.vh"

// ----------------------------------------------------------------------------
// Control state
// ----------------------------------------------------------------------------
reg timer_sync_hold_ff;
reg shared_rst_ff;
reg second_rst_ff;
reg [2:0] sel0_ff;
reg [2:0] sel1_ff;
// Write flag and address held from the address phase into the data phase.
reg wr_pend_ff;
reg [11:0] wr_addr_ff;
// Next values of the state above.
reg nxt_hold;
reg nxt_shared;
reg nxt_second;
reg [2:0] nxt_sel0;
reg [2:0] nxt_sel1;
reg [31:0] nxt_rdata;
reg nxt_tick0;
reg nxt_tick1;

wire tap8;
wire tap64;
wire tap256;
wire tap1024;
wire rise0;
wire fall0;
wire rise1;
wire fall1;
wire addr_phase;
wire [2:0] rd_hit;
wire [2:0] wr_hit;

// ----------------------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------------------
// Each register answers to one word address; any other address reads zero.
function [2:0] reg_hit;
   input [11:0] addr;
   begin
      if (addr == `STP_SYNC_CTRL_ADDR)
      begin
         reg_hit = 3'h1;
      end
      else if (addr == `STP_TIMER_SEL_ADDR)
      begin
         reg_hit = 3'h2;
      end
      else if (addr == `STP_STATUS_ADDR)
      begin
         reg_hit = 3'h4;
      end
      else
      begin
         reg_hit = 3'h0;
      end
   end
endfunction

// A transfer is taken only while the bus is ready and the slave is selected.
assign addr_phase = hsel & hready & htrans[1];
assign rd_hit = reg_hit(haddr);
assign wr_hit = reg_hit(wr_addr_ff);

// ----------------------------------------------------------------------------
// Divider and pin edge detectors
// ----------------------------------------------------------------------------
// Both timers draw on this one divider, so a restart moves the phase of both.
stp_divider u_div
(
   .clk_sys(clk_sys),
   .rst_b(rst_b),
   .restart(shared_rst_ff),
   .tap8_ff(tap8),
   .tap64_ff(tap64),
   .tap256_ff(tap256),
   .tap1024_ff(tap1024)
);

stp_pin_edge u_pin0
(
   .clk_sys(clk_sys),
   .rst_b(rst_b),
   .external_count_pin(external_count_pin_0),
   .rise_ff(rise0),
   .fall_ff(fall0)
);

stp_pin_edge u_pin1
(
   .clk_sys(clk_sys),
   .rst_b(rst_b),
   .external_count_pin(external_count_pin_1),
   .rise_ff(rise1),
   .fall_ff(fall1)
);

// ----------------------------------------------------------------------------
// Source select
// ----------------------------------------------------------------------------
// The shared reset bit masks divided and undivided ticks only; pin ticks pass through.
function pick_tick;
   input [2:0] sel;
   input halt;
   input t8;
   input t64;
   input t256;
   input t1024;
   input rise;
   input fall;
   begin
      case (sel)
         `STP_SEL_DIV1: pick_tick = ~halt;
         `STP_SEL_DIV8: pick_tick = t8 & ~halt;
         `STP_SEL_DIV64: pick_tick = t64 & ~halt;
         `STP_SEL_DIV256: pick_tick = t256 & ~halt;
         `STP_SEL_DIV1024: pick_tick = t1024 & ~halt;
         `STP_SEL_EXT_FALL: pick_tick = fall;
         `STP_SEL_EXT_RISE: pick_tick = rise;
         default: pick_tick = 1'b0;
      endcase
   end
endfunction

always @*
begin
   // Each timer has its own select and pin; the taps are common.
   nxt_tick0 = pick_tick(sel0_ff, shared_rst_ff, tap8, tap64, tap256, tap1024, rise0, fall0);
   nxt_tick1 = pick_tick(sel1_ff, shared_rst_ff, tap8, tap64, tap256, tap1024, rise1, fall1);
end

// ----------------------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------------------
always @*
begin
   nxt_hold = timer_sync_hold_ff;
   nxt_shared = shared_rst_ff & timer_sync_hold_ff;
   nxt_second = second_rst_ff & timer_sync_hold_ff;
   nxt_sel0 = sel0_ff;
   nxt_sel1 = sel1_ff;
   // A write lands at the end of its data phase, when hwdata stands.
   if (wr_pend_ff)
   begin
      if (wr_hit[0])
      begin
         nxt_hold = hwdata[`STP_SYNC_HOLD_BIT];
         if (hwdata[`STP_SYNC_HOLD_BIT])
         begin
            nxt_shared = nxt_shared | hwdata[`STP_SHARED_RST_BIT];
            nxt_second = nxt_second | hwdata[`STP_SECOND_RST_BIT];
         end
         else
         begin
            nxt_shared = 1'b0;
            nxt_second = 1'b0;
            if (!timer_sync_hold_ff)
            begin
               nxt_shared = hwdata[`STP_SHARED_RST_BIT];
               nxt_second = hwdata[`STP_SECOND_RST_BIT];
            end
         end
      end
      else if (wr_hit[1])
      begin
         nxt_sel0 = hwdata[`STP_SEL0_LSB +: 3];
         nxt_sel1 = hwdata[`STP_SEL1_LSB +: 3];
      end
   end
end

// ----------------------------------------------------------------------------
// Read data
// ----------------------------------------------------------------------------
always @*
begin
   nxt_rdata = 32'h0000_0000;
   // Read data are chosen in the address phase and registered, so they stand
   // through the data phase and fall back to zero after it.
   if (addr_phase & ~hwrite)
   begin
      if (rd_hit[0])
      begin
         nxt_rdata[`STP_SYNC_HOLD_BIT] = timer_sync_hold_ff;
         nxt_rdata[`STP_SECOND_RST_BIT] = second_rst_ff;
         nxt_rdata[`STP_SHARED_RST_BIT] = shared_rst_ff;
      end
      else if (rd_hit[1])
      begin
         nxt_rdata[`STP_SEL0_LSB +: 3] = sel0_ff;
         nxt_rdata[`STP_SEL1_LSB +: 3] = sel1_ff;
      end
      else if (rd_hit[2])
      begin
         nxt_rdata[0] = timer_tick_0;
         nxt_rdata[1] = timer_tick_1;
         nxt_rdata[2] = shared_rst_ff | timer_sync_hold_ff;
      end
   end
end

// ----------------------------------------------------------------------------
// Bus response
// ----------------------------------------------------------------------------
always @(posedge clk_sys or negedge rst_b)
begin
   if (!rst_b)
   begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
   end
   else
   begin
      wr_pend_ff <= addr_phase & hwrite;
      wr_addr_ff <= haddr;
      hrdata <= nxt_rdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
   end
end

// ----------------------------------------------------------------------------
// Control register
// ----------------------------------------------------------------------------
// The exported second reset level is a copy of the held bit, so it changes in
// the same cycle as the value that software reads back.
always @(posedge clk_sys or negedge rst_b)
begin
   if (!rst_b)
   begin
      timer_sync_hold_ff <= 1'b0;
      shared_rst_ff <= 1'b0;
      second_rst_ff <= 1'b0;
      second_prescaler_reset <= 1'b0;
   end
   else
   begin
      timer_sync_hold_ff <= nxt_hold;
      shared_rst_ff <= nxt_shared;
      second_rst_ff <= nxt_second;
      second_prescaler_reset <= nxt_second;
   end
end

// ----------------------------------------------------------------------------
// Timer source select
// ----------------------------------------------------------------------------
always @(posedge clk_sys or negedge rst_b)
begin
   if (!rst_b)
   begin
      sel0_ff <= `STP_SEL_RST;
      sel1_ff <= `STP_SEL_RST;
   end
   else
   begin
      sel0_ff <= nxt_sel0;
      sel1_ff <= nxt_sel1;
   end
end

// ----------------------------------------------------------------------------
// Timer ticks
// ----------------------------------------------------------------------------
// Ticks are registered once more so that every output comes from a flip-flop;
// this adds one cycle to every source, the undivided one included.
always @(posedge clk_sys or negedge rst_b)
begin
   if (!rst_b)
   begin
      timer_tick_0 <= 1'b0;
      timer_tick_1 <= 1'b0;
   end
   else
   begin
      timer_tick_0 <= nxt_tick0;
      timer_tick_1 <= nxt_tick1;
   end
end

endmodule // stp_prescaler

`default_nettype wire

// *** hw/stp_regs.vh ***
/*
 * Offsets, field positions, reset values and tap ratios of the shared timer prescaler.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef STP_REGS_VH
`define STP_REGS_VH

// ----------------------------------------------------------------------------
// Register map (byte addresses on the AHB-Lite bus)
// ----------------------------------------------------------------------------
`define STP_SYNC_CTRL_ADDR 12'h000
`define STP_TIMER_SEL_ADDR 12'h004
`define STP_STATUS_ADDR 12'h008

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define STP_SYNC_HOLD_BIT 7
`define STP_SECOND_RST_BIT 1
`define STP_SHARED_RST_BIT 0
`define STP_SEL0_LSB 0
`define STP_SEL1_LSB 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define STP_SYNC_CTRL_RST 8'h00
`define STP_SEL_RST 3'h0

// ----------------------------------------------------------------------------
// Clock source select codes
// ----------------------------------------------------------------------------
`define STP_SEL_STOP 3'h0
`define STP_SEL_DIV1 3'h1
`define STP_SEL_DIV8 3'h2
`define STP_SEL_DIV64 3'h3
`define STP_SEL_DIV256 3'h4
`define STP_SEL_DIV1024 3'h5
`define STP_SEL_EXT_FALL 3'h6
`define STP_SEL_EXT_RISE 3'h7

// ----------------------------------------------------------------------------
// Divider taps: the tap fires when the low bits of the counter are all ones
// ----------------------------------------------------------------------------
`define STP_DIV_WIDTH 10
`define STP_TAP8_MASK 10'h007
`define STP_TAP64_MASK 10'h03f
`define STP_TAP256_MASK 10'h0ff
`define STP_TAP1024_MASK 10'h3ff

`endif

// *** hw/stp_divider.v ***
/*
 * Free-running 10-bit divider of the system clock with four enable taps.
 * Assumes a synchronous restart request from the control register logic.
 */
`default_nettype none

module stp_divider
(
   input wire clk_sys,
   input wire rst_b,
   input wire restart,
   output reg tap8_ff,
   output reg tap64_ff,
   output reg tap256_ff,
   output reg tap1024_ff
);

`include "stp_regs.vh"

reg [`STP_DIV_WIDTH-1:0] count_ff;
reg [`STP_DIV_WIDTH-1:0] nxt_count;

function tap_hit;
   input [`STP_DIV_WIDTH-1:0] cnt;
   input [`STP_DIV_WIDTH-1:0] mask;
   begin
      tap_hit = ((cnt & mask) == mask);
   end
endfunction

// ----------------------------------------------------------------------------
// Counter and taps
// ----------------------------------------------------------------------------
always @*
begin
   nxt_count = count_ff + 10'h001;
end

always @(posedge clk_sys or negedge rst_b)
begin
   if (!rst_b)
   begin
      count_ff <= 10'h000;
      tap8_ff <= 1'b0;
      tap64_ff <= 1'b0;
      tap256_ff <= 1'b0;
      tap1024_ff <= 1'b0;
   end
   else if (restart)
   begin
      count_ff <= 10'h000;
      tap8_ff <= 1'b0;
      tap64_ff <= 1'b0;
      tap256_ff <= 1'b0;
      tap1024_ff <= 1'b0;
   end
   else
   begin
      count_ff <= nxt_count;
      tap8_ff <= tap_hit(count_ff, `STP_TAP8_MASK);
      tap64_ff <= tap_hit(count_ff, `STP_TAP64_MASK);
      tap256_ff <= tap_hit(count_ff, `STP_TAP256_MASK);
      tap1024_ff <= tap_hit(count_ff, `STP_TAP1024_MASK);
   end
end

endmodule // stp_divider

`default_nettype wire

// *** hw/stp_pin_edge.v ***
/*
 * Synchroniser and edge detector for one external count pin.
 * Assumes an asynchronous pin; output pulses are one system clock wide.
 */
`default_nettype none

module stp_pin_edge
(
   input wire clk_sys,
   input wire rst_b,
   input wire external_count_pin,
   output reg rise_ff,
   output reg fall_ff
);

reg sync1_ff;
reg sync2_ff;
reg last_ff;

// ----------------------------------------------------------------------------
// Two-stage sampler then edge compare
// ----------------------------------------------------------------------------
always @(posedge clk_sys or negedge rst_b)
begin
   if (!rst_b)
   begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      last_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
   end
   else
   begin
      sync1_ff <= external_count_pin;
      sync2_ff <= sync1_ff;
      last_ff <= sync2_ff;
      rise_ff <= sync2_ff & ~last_ff;
      fall_ff <= ~sync2_ff & last_ff;
   end
end

endmodule // stp_pin_edge

`default_nettype wire

// *** testbench/stp_pin_model.sv ***
/* Partner model: an external count source on the count pins.
   Assumes the system clock runs free; the pin moves only while enabled. */
`default_nettype none
module stp_pin_model
#(
   parameter int HALF = 2
)
(
   input wire logic clk_sys,
   input wire logic en,
   output var logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial pin = 1'b0;
   // ----------------------------------------------------------------
   // Source
   // ----------------------------------------------------------------
   // Each level lasts HALF system cycles, so at the default HALF of 2 the rate is a quarter.
   always @(posedge clk_sys)
   begin
      if (!en)
         cnt <= 0;
      else if (cnt == HALF - 1)
      begin
         cnt <= 0;
         pin <= ~pin;
      end
      else
         cnt <= cnt + 1;
   end
endmodule // stp_pin_model
`default_nettype wire

// *** testbench/stp_prescaler_props.sv ***
/* Port checker of the shared timer prescaler.
   Assumes binding to stp_prescaler, whose hreadyout is the bus's hready. */
`default_nettype none
module stp_prescaler_props
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic external_count_pin_0,
   input wire logic timer_tick_0,
   input wire logic second_prescaler_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr_ff, hold_ff, hr_ff, sr_ff;
   logic [11:0] a_ff;
   logic [2:0] sel_ff;
   logic [3:0] calm_ff, gap_ff;
   // ----------------------------------------------------------------
   // Shadow of the control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         {wr_ff, hold_ff, hr_ff, sr_ff} <= 4'h0;
         {a_ff, sel_ff, calm_ff, gap_ff} <= '0;
      end
      else
      begin
         wr_ff <= hsel & htrans[1] & hwrite;
         a_ff <= haddr;
         gap_ff <= timer_tick_0 ? 4'h0 : gap_ff + {3'h0, gap_ff != 4'hf};
         calm_ff <= (wr_ff && a_ff < 12'h008) ? 4'h0 : calm_ff + {3'h0, calm_ff != 4'hf};
         if (wr_ff && a_ff == 12'h004)
            sel_ff <= hwdata[2:0];
         if (wr_ff && a_ff == 12'h000)
         begin
            hold_ff <= hwdata[7];
            hr_ff <= hwdata[7] & (hr_ff | hwdata[0]);
            sr_ff <= hwdata[7] & (sr_ff | hwdata[1]);
         end
      end
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
   stop_quiet_a: assert property (sel_ff == 3'h0 && calm_ff > 4'h5 |-> !timer_tick_0)
      else $error("tick while stopped");
   div1_full_a: assert property (sel_ff == 3'h1 && calm_ff > 4'h2 && !hr_ff |-> timer_tick_0)
      else $error("undivided tick missing");
   div8_gap_a: assert property (sel_ff == 3'h2 && calm_ff > 4'hb && !hr_ff && timer_tick_0
      |-> gap_ff == 4'h7) else $error("divide by 8 period wrong");
   held_halt_a: assert property (hr_ff && calm_ff > 4'h1 && sel_ff < 3'h6 |-> !timer_tick_0)
      else $error("tick while prescaler held");
   second_rst_a: assert property (calm_ff > 4'h1 |-> second_prescaler_reset == sr_ff)
      else $error("second reset level wrong");
   pin_rise_a: assert property (sel_ff == 3'h7 && calm_ff > 4'h7 && $rose(external_count_pin_0)
      |-> ##[2:5] timer_tick_0) else $error("rising pin edge not counted");
   pin_fall_a: assert property (sel_ff == 3'h6 && calm_ff > 4'h7 && $fell(external_count_pin_0)
      |-> ##[2:5] timer_tick_0) else $error("falling pin edge not counted");
   pin_once_a: assert property (sel_ff[2:1] == 2'b11 && calm_ff > 4'h2 && timer_tick_0
      |=> !timer_tick_0) else $error("pin tick wider than one cycle");
   cover property (sel_ff == 3'h2 && timer_tick_0);
   cover property (hr_ff && calm_ff > 4'h1);
   cover property (sel_ff == 3'h7 && timer_tick_0);
endmodule // stp_prescaler_props
bind stp_prescaler stp_prescaler_props u_props (.*);
`default_nettype wire

// *** testbench/tb_stp_prescaler.sv ***
/* Testbench of the shared timer prescaler: bus tasks, tick counts, pin source.
   Assumes the design, the pin model and the checker are compiled before it. */
`include "stp_regs.vh"
`default_nettype none
module tb_stp_prescaler;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, rst_b = 0, hsel = 0, hwrite = 0, en = 0;
   logic [11:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic [31:0] hwdata = '0, hrdata, q;
   logic hready, hresp, pin, tick0, tick1, sr;
   int errors = 0, n_tests = 0, c0, c1, d1, d2;
   int exp_n[6] = '{0, 1024, 128, 16, 4, 1};
   stp_prescaler DUT
   (
      .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .external_count_pin_0(pin),
      .external_count_pin_1(pin), .timer_tick_0(tick0), .timer_tick_1(tick1),
      .second_prescaler_reset(sr)
   );
   stp_pin_model PIN (.clk_sys(clk_sys), .en(en), .pin(pin));
   initial forever #5 clk_sys = ~clk_sys;
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic end_of_test;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e)
      begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wt;
      int k;
      k = 0;
      do
      begin
         @(posedge clk_sys);
         k++;
      end
      while (hready !== 1'b1 && k < 50);
      if (hready !== 1'b1)
      begin
         errors++;
         end_of_test;
      end
   endtask
   task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      wt;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wt;
      r = hrdata;
   endtask
   task automatic cnt(input int n, output int a, output int b);
      a = 0;
      b = 0;
      repeat (n)
      begin
         @(negedge clk_sys);
         a += (tick0 === 1'b1);
         b += (tick1 === 1'b1);
      end
      @(posedge clk_sys);
   endtask
   task automatic first(output int d);
      d = 0;
      do
      begin
         @(negedge clk_sys);
         d++;
      end
      while (tick1 !== 1'b1 && d < 2000);
      if (tick1 !== 1'b1)
      begin
         errors++;
         end_of_test;
      end
      @(posedge clk_sys);
   endtask
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      xf(1'b1, 12'h010, 32'hffff_ffff, q);
      for (int i = 0; i < 5; i++)
      begin
         xf(1'b0, 12'(4 * i), 32'h0000_0000, q);
         chk(q, 32'h0000_0000);
      end
      for (int k = 0; k < 6; k++)
      begin
         xf(1'b1, `STP_TIMER_SEL_ADDR, 32'(k + 16 * (5 - k)), q);
         cnt(4, c0, c1);
         cnt(1024, c0, c1);
         chk(c0, exp_n[k]);
         chk(c1, exp_n[5 - k]);
      end
      xf(1'b1, `STP_TIMER_SEL_ADDR, 32'h0000_0021, q);
      xf(1'b1, `STP_SYNC_CTRL_ADDR, 32'h0000_0081, q);
      cnt(2, c0, c1);
      cnt(20, c0, c1);
      chk(c0 + c1, 0);
      xf(1'b0, `STP_SYNC_CTRL_ADDR, 32'h0000_0000, q);
      chk(q, 32'h0000_0081);
      xf(1'b0, `STP_STATUS_ADDR, 32'h0000_0000, q);
      chk(q, 32'h0000_0004);
      xf(1'b1, `STP_SYNC_CTRL_ADDR, 32'h0000_0082, q);
      cnt(2, c0, c1);
      chk(sr, 1'b1);
      xf(1'b1, `STP_SYNC_CTRL_ADDR, 32'h0000_0000, q);
      cnt(4, c0, c1);
      cnt(16, c0, c1);
      chk(c0, 16);
      chk(c1, 2);
      chk(sr, 1'b0);
      xf(1'b1, `STP_SYNC_CTRL_ADDR, 32'h0000_0001, q);
      first(d1);
      xf(1'b0, `STP_SYNC_CTRL_ADDR, 32'h0000_0000, q);
      chk(q, 32'h0000_0000);
      xf(1'b1, `STP_SYNC_CTRL_ADDR, 32'h0000_0001, q);
      first(d2);
      chk(d2, d1);
      chk(d1, 11);
      xf(1'b1, `STP_TIMER_SEL_ADDR, 32'h0000_0001, q);
      xf(1'b1, `STP_TIMER_SEL_ADDR, 32'h0000_0021, q);
      first(d1);
      chk(d1 > 1 && d1 < 11, 1'b1);
      for (int k = 0; k < 2; k++)
      begin
         xf(1'b1, `STP_TIMER_SEL_ADDR, k ? 32'h0000_0076 : 32'h0000_0067, q);
         cnt(10, c0, c1);
         en <= 1'b1;
         cnt(160, c0, c1);
         en <= 1'b0;
         cnt(10, d1, d2);
         chk(c0 + d1, 40);
         chk(c1 + d2, 40);
      end
      end_of_test;
   end
endmodule // tb_stp_prescaler
`default_nettype wire
